/* logic/isd_cfg.svh */
`ifndef ISD_CFG_SVH
`define ISD_CFG_SVH
// register byte offsets
`define ADDR_INSTR 4'h0
`define ADDR_WREG 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_FADDR 4'hc
// status field positions
`define ST_C 0
`define ST_DIGIT_CARRY 1
`define ST_Z 2
`define ST_POWER_DOWN 3
`define ST_EXPIRY 4
`define ST_SLEEP 5
// reset values
`define STATUS_RST 8'h18
`define WREG_RST 8'h00
`define WATCHDOG_RST 8'h00
`define PRE_RST 8'h00
// timing counts: the prescaler wraps after this value, one watchdog step per wrap
`define PRE_LAST 8'hff
// opcodes
`define OP_SLEEP 14'h0063
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* logic/isd_pkg.sv */
package isd_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_IOR = 3'b001,
        OP_LOAD_LIT = 3'b010,
        OP_COPY_FILE = 3'b011,
        OP_STORE_W = 3'b100,
        OP_LIT_MINUS_W = 3'b101,
        OP_SLEEP = 3'b110
    } op_kind_t;
endpackage

/* logic/instruction_subset_decode.sv */
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "isd_cfg.svh"
////////////////////////////////////////////////////////////////////////
module instruction_subset_decode
    import isd_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core status
    output logic sleep_q,
    output logic [7:0] watchdog_counter_q
);

    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] file_mem [FILE_DEPTH];
    logic [7:0] wreg_q;
    logic [7:0] status_q;
    logic [7:0] prescale_q;
    logic [6:0] faddr_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic exec_q;
    logic [13:0] instr_q;

    ////////////////////////////////////////////////////////////////////////
    // decode; don't-care bits are simply not compared
    op_kind_t op;
    always_comb begin
        op = OP_NONE;
        if (instr_q[13:8] == 6'b000100) begin
            op = OP_IOR;
        end else if (instr_q[13:10] == 4'b1100) begin
            op = OP_LOAD_LIT;
        end else if (instr_q[13:8] == 6'b001000) begin
            op = OP_COPY_FILE;
        end else if (instr_q[13:7] == 7'b0000001) begin
            op = OP_STORE_W;
        end else if (instr_q[13:9] == 5'b11110) begin
            op = OP_LIT_MINUS_W;
        end else if (instr_q == `OP_SLEEP) begin
            op = OP_SLEEP;
        end
    end

    logic [6:0] fa;
    logic dest;
    logic [7:0] fval;
    logic [7:0] lit;
    logic [7:0] res;
    logic [8:0] sub9;
    logic [4:0] sub5;
    assign fa = instr_q[6:0];
    assign dest = instr_q[7];
    assign fval = file_mem[fa];
    assign lit = instr_q[7:0];
    // literal + ~w + 1; carry out means no borrow
    assign sub9 = {1'b0, lit} + {1'b0, ~wreg_q} + 9'h001;
    assign sub5 = {1'b0, lit[3:0]} + {1'b0, ~wreg_q[3:0]} + 5'h01;

    // result selection per operation
    always_comb begin
        case (op)
            OP_IOR: res = wreg_q | fval;
            OP_COPY_FILE: res = fval;
            OP_LIT_MINUS_W: res = sub9[7:0];
            OP_LOAD_LIT: res = lit;
            default: res = wreg_q;
        endcase
    end

    logic run;
    assign run = exec_q && !sleep_q;

    ////////////////////////////////////////////////////////////////////////
    // working register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_q <= `WREG_RST;
        end else if (run && (op == OP_LOAD_LIT || op == OP_LIT_MINUS_W)) begin
            wreg_q <= res;
        end else if (run && (op == OP_IOR || op == OP_COPY_FILE) && !dest) begin
            wreg_q <= res;
        end else if (aw_hold_q && w_hold_q && awaddr_q == `ADDR_WREG && !s_axi_bvalid
                && !sleep_q) begin
            // a halted core keeps its working register, even against the bus
            wreg_q <= wdata_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // file memory, no reset: contents are undefined at power-up
    always_ff @(posedge aclk) begin
        if (run && op == OP_STORE_W) begin
            file_mem[fa] <= wreg_q;
        end else if (run && (op == OP_IOR || op == OP_COPY_FILE) && dest) begin
            file_mem[fa] <= res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= `STATUS_RST;
        end else if (run) begin
            case (op)
                OP_IOR, OP_COPY_FILE: status_q[`ST_Z] <= (res == 8'h00);
                OP_LIT_MINUS_W: begin
                    status_q[`ST_C] <= sub9[8];
                    status_q[`ST_DIGIT_CARRY] <= sub5[4];
                    status_q[`ST_Z] <= (sub9[7:0] == 8'h00);
                end
                OP_SLEEP: begin
                    status_q[`ST_POWER_DOWN] <= 1'b0;
                    status_q[`ST_EXPIRY] <= 1'b1;
                end
                default: status_q <= status_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog and prescaler; free-run while awake, frozen asleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_counter_q <= `WATCHDOG_RST;
            prescale_q <= `PRE_RST;
            sleep_q <= 1'b0;
        end else if (run && op == OP_SLEEP) begin
            watchdog_counter_q <= `WATCHDOG_RST;
            prescale_q <= `PRE_RST;
            sleep_q <= 1'b1;
        end else if (!sleep_q) begin
            prescale_q <= prescale_q + 8'h01;
            if (prescale_q == `PRE_LAST) begin
                watchdog_counter_q <= watchdog_counter_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi write channel; address and data taken in either order
    logic wr_go;
    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == `ADDR_INSTR || awaddr_q == `ADDR_WREG
                    || awaddr_q == `ADDR_FADDR) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    // instruction issue: a write to the instruction register executes once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exec_q <= 1'b0;
            instr_q <= 14'h0;
            faddr_q <= 7'h0;
        end else begin
            exec_q <= wr_go && awaddr_q == `ADDR_INSTR;
            if (wr_go && awaddr_q == `ADDR_INSTR) begin
                instr_q <= wdata_q[13:0];
            end
            if (wr_go && awaddr_q == `ADDR_FADDR) begin
                faddr_q <= wdata_q[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read channel, one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_INSTR: s_axi_rdata <= {18'h0, instr_q};
                    `ADDR_WREG: s_axi_rdata <= {24'h0, wreg_q};
                    `ADDR_STATUS: s_axi_rdata <= {24'h0, status_q[7:6], sleep_q,
                        status_q[4:0]};
                    `ADDR_FADDR: s_axi_rdata <= {16'h0, file_mem[faddr_q], 1'b0, faddr_q};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // datapath results, one cycle after the executing edge; the literal-load decode on the same edge
    a_or_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_IOR |=> status_q[`ST_Z] == ($past(res) == 8'h00))
        else $error("or zero flag wrong");
    a_or_dest: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_IOR && !dest |=> wreg_q == $past(res))
        else $error("or result not in working");
    a_or_file: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_IOR && dest |=> file_mem[fa] == $past(res) && $stable(wreg_q))
        else $error("or result not in file");
    a_literal_load: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_LOAD_LIT |=> wreg_q == $past(lit) && $stable(status_q))
        else $error("literal load wrong");
    a_load_decode: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_q && instr_q[13:10] == 4'b1100 |-> op == OP_LOAD_LIT)
        else $error("literal load not decoded");
    a_copy_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_COPY_FILE |=> status_q[`ST_Z] == ($past(fval) == 8'h00))
        else $error("copy zero flag wrong");
    a_copy_dest: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_COPY_FILE && !dest |=> wreg_q == $past(fval))
        else $error("copy not in working");
    a_copy_self: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_COPY_FILE && dest |=> file_mem[fa] == $past(fval) && $stable(wreg_q))
        else $error("copy onto itself changed data");
    a_store_write: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_STORE_W |=> file_mem[fa] == $past(wreg_q))
        else $error("store missed the file");
    a_store_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_STORE_W |=> $stable(status_q) && $stable(wreg_q))
        else $error("store changed flags");
    a_sub_result: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_LIT_MINUS_W |=> wreg_q == 8'($past(lit) - $past(wreg_q)))
        else $error("subtract result wrong");
    a_sub_carry: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_LIT_MINUS_W |=> status_q[`ST_C] == ($past(lit) >= $past(wreg_q)))
        else $error("subtract carry wrong");
    a_sub_digit: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_LIT_MINUS_W |=>
            status_q[`ST_DIGIT_CARRY] == ($past(lit[3:0]) >= $past(wreg_q[3:0])))
        else $error("subtract digit carry wrong");
    a_sub_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_LIT_MINUS_W |=> status_q[`ST_Z] == ($past(lit) == $past(wreg_q)))
        else $error("subtract zero flag wrong");

    // power-down and issue
    a_sleep_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_SLEEP |=> !status_q[`ST_POWER_DOWN] && status_q[`ST_EXPIRY])
        else $error("power-down flags wrong");
    a_sleep_watchdog: assert property (@(posedge aclk) disable iff (!aresetn)
        run && op == OP_SLEEP |=> watchdog_counter_q == 8'h00 && prescale_q == 8'h00)
        else $error("watchdog not cleared");
    a_sleep_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_q |=> sleep_q && $stable(wreg_q) && $stable(watchdog_counter_q))
        else $error("core ran while asleep");
    a_exec_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_q |=> !exec_q)
        else $error("one write executed twice");

    // bus answers stand until taken; readies are single pulses
    a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awready |=> !s_axi_awready)
        else $error("write address ready held");
    a_read_ready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arready |=> !s_axi_arready)
        else $error("read address ready held");

    // main scenarios
    c_sleep: cover property (@(posedge aclk) run && op == OP_SLEEP);
    c_sub_zero: cover property (@(posedge aclk) run && op == OP_LIT_MINUS_W && sub9[7:0] == 8'h00);
    c_copy_self: cover property (@(posedge aclk) run && op == OP_COPY_FILE && dest);
    c_load_dontcare: cover property (@(posedge aclk) run && op == OP_LOAD_LIT && instr_q[9:8] == 2'b11);
    c_store: cover property (@(posedge aclk) run && op == OP_STORE_W);

endmodule // instruction_subset_decode

/* test/instruction_subset_decode_test.sv */
`timescale 1ns/10ps
`include "isd_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module instruction_subset_decode_test;
    logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, slp;
    logic [3:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] bresp, rresp;
    logic [7:0] wdog, st;
    int bad_count, n_tests, cyc;

    instruction_subset_decode uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .sleep_q(slp), .watchdog_counter_q(wdog)
    );

    ////////////////////////////////////////////////////////////////////////
    // 25 mhz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // hang guard, well above the roughly 1500 cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 6000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out;
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bus tasks; each opens on a fresh edge so no signal is driven twice at once
    // no wait limit of its own: only the hang guard ends a stuck transfer
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        resp = bresp;
        br <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rd;
        resp = rresp;
        rr <= 1'b0;
    endtask

    task automatic exec(input logic [13:0] op);
        logic [1:0] r;
        wr_reg(`ADDR_INSTR, {18'h0, op}, r);
        `CHK("bresp", `RESP_OKAY, r)
    endtask

    task automatic expect_reg(input string nm, input logic [3:0] a, input logic [7:0] v);
        logic [31:0] d;
        logic [1:0] r;
        rd_reg(a, d, r);
        `CHK(nm, {24'h0, v}, d)
    endtask

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        st = `STATUS_RST;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        expect_reg("st_rst", `ADDR_STATUS, `STATUS_RST);
        expect_reg("w_rst", `ADDR_WREG, `WREG_RST);
        `CHK("slp_rst", 1'b0, slp)
    endtask

    task automatic t_copy;
        logic [1:0] r;
        wr_reg(`ADDR_WREG, 32'h0000_00a5, r);
        `CHK("wr_w", `RESP_OKAY, r)
        expect_reg("w_bus", `ADDR_WREG, 8'ha5);
        exec(14'h3000);
        exec(14'h0085);
        exec(14'h3077);
        exec(14'h0885);
        st = 8'h1c;
        expect_reg("w_kept", `ADDR_WREG, 8'h77);
        expect_reg("z_self", `ADDR_STATUS, st);
    endtask

    // every value of the two ignored opcode bits
    task automatic t_load;
        logic [7:0] k;
        for (int x = 0; x < 4; x++) begin
            k = 8'h3c + 8'(x);
            exec({4'hc, 2'(x), k});
            expect_reg("w_lit", `ADDR_WREG, k);
            expect_reg("st_lit", `ADDR_STATUS, st);
        end
    endtask

    // top file address as the boundary case
    task automatic t_or;
        logic [31:0] d;
        logic [1:0] r;
        exec(14'h3013);
        exec(14'h00ff);
        expect_reg("st_store", `ADDR_STATUS, st);
        exec(14'h3091);
        exec(14'h047f);
        st = 8'h18;
        expect_reg("w_or", `ADDR_WREG, 8'h93);
        expect_reg("st_or", `ADDR_STATUS, st);
        exec(14'h300c);
        exec(14'h04ff);
        expect_reg("w_or_f", `ADDR_WREG, 8'h0c);
        exec(14'h087f);
        expect_reg("f_or", `ADDR_WREG, 8'h1f);
        // peek at the file: content in bits 15:8, pointer in bits 6:0
        wr_reg(`ADDR_FADDR, 32'h0000_007f, r);
        `CHK("wr_fa", `RESP_OKAY, r)
        rd_reg(`ADDR_FADDR, d, r);
        `CHK("f_peek", 32'h0000_1f7f, d)
        rd_reg(`ADDR_INSTR, d, r);
        `CHK("instr_rd", 32'h0000_087f, d)
    endtask

    // positive, zero and negative results; carry means no borrow
    task automatic t_sub;
        logic [7:0] w, r;
        for (int i = 1; i < 4; i++) begin
            w = 8'(i);
            r = 8'h02 - w;
            exec({6'h30, w});
            exec({5'h1e, 1'(i), 8'h02});
            st = {3'b000, st[4:3], r == 8'h00, 4'h2 >= w[3:0], 8'h02 >= w};
            expect_reg("w_sub", `ADDR_WREG, r);
            expect_reg("st_sub", `ADDR_STATUS, st);
        end
    endtask

    task automatic t_err;
        logic [31:0] d;
        logic [1:0] r;
        wr_reg(`ADDR_STATUS, 32'h0000_00ff, r);
        `CHK("wr_ro", `RESP_SLVERR, r)
        expect_reg("st_ro", `ADDR_STATUS, st);
        rd_reg(4'h2, d, r);
        `CHK("rd_bad", `RESP_SLVERR, r)
        `CHK("rd_bad_d", 32'h0, d)
    endtask

    // let the watchdog advance first so the clear is visible
    task automatic t_sleep;
        logic [1:0] r;
        repeat (600) @(posedge aclk);
        `CHK("wdog_run", 1'b1, wdog != 8'h00)
        exec(`OP_SLEEP);
        st = (st & 8'hf7) | 8'h30;
        expect_reg("st_slp", `ADDR_STATUS, st);
        `CHK("wdog_clr", 8'h00, wdog)
        `CHK("slp", 1'b1, slp)
        repeat (600) @(posedge aclk);
        `CHK("wdog_hold", 8'h00, wdog)
        exec(14'h3055);
        expect_reg("w_slp", `ADDR_WREG, 8'hff);
        wr_reg(`ADDR_WREG, 32'h0000_0011, r);
        `CHK("wr_w_slp", `RESP_OKAY, r)
        expect_reg("w_frozen", `ADDR_WREG, 8'hff);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        aresetn = 1'b0;
        awa = 4'h0; wd = 32'h0; awv = 1'b0; wv = 1'b0; br = 1'b0;
        ara = 4'h0; arv = 1'b0; rr = 1'b0;
        do_reset;
        t_reset;
        t_copy;
        t_load;
        t_or;
        t_sub;
        t_err;
        t_sleep;
        do_reset;
        t_reset;
        close_out;
    end
endmodule // instruction_subset_decode_test
